// ---- include/cemb_pkg.sv ----
// Constants shared by the embedded memory block: organisations, register map, field positions.
// Assumes a 32-bit AXI4-Lite master and user logic on the same clock.
package cemb_pkg;
   localparam int          ADDR_W     = 11;
   localparam int          DATA_W     = 8;
   localparam int          ROWS       = 256;
   localparam int          ROW_W      = 8;
   localparam int          LANE_W     = 3;
   localparam int          AXI_AW     = 4;
   localparam int          AXI_DW     = 32;

   // Word organisations
   localparam logic [1:0]  ORG_256X8  = 2'h0;
   localparam logic [1:0]  ORG_512X4  = 2'h1;
   localparam logic [1:0]  ORG_1KX2   = 2'h2;
   localparam logic [1:0]  ORG_2KX1   = 2'h3;

   // Lane masks per organisation
   localparam logic [7:0]  MASK_X8    = 8'hff;
   localparam logic [7:0]  MASK_X4    = 8'h0f;
   localparam logic [7:0]  MASK_X2    = 8'h03;
   localparam logic [7:0]  MASK_X1    = 8'h01;

   // Register byte offsets
   localparam logic [3:0]  REG_CTRL      = 4'h0;
   localparam logic [3:0]  REG_LOAD_ADDR = 4'h4;
   localparam logic [3:0]  REG_LOAD_DATA = 4'h8;
   localparam logic [3:0]  REG_STATUS    = 4'hc;

   // Control fields
   localparam int          CTRL_ORG_LSB  = 0;
   localparam int          CTRL_ORG_MSB  = 1;
   localparam int          CTRL_DIN_REG  = 2;
   localparam int          CTRL_ADR_REG  = 3;
   localparam int          CTRL_OUT_REG  = 4;
   localparam int          CTRL_ROM      = 5;
   localparam int          CTRL_W        = 6;
   localparam logic [5:0]  CTRL_RST      = 6'h00;

   // Status fields
   localparam int          STAT_ORG_LSB  = 8;

   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ---- hw/cemb_array.sv ----
// Flip-flop storage array of 256 rows by 8 bits with one masked write port
// and two combinational read ports; the caller maps organisations onto rows.
`timescale 1ns/1ps
module cemb_array (
   input  wire logic                        sys_clk_i,
   input  wire logic                        arst_n_i,
   input  wire logic                        wr_en_i,
   input  wire logic [cemb_pkg::ROW_W-1:0]  wr_row_i,
   input  wire logic [cemb_pkg::DATA_W-1:0] wr_mask_i,
   input  wire logic [cemb_pkg::DATA_W-1:0] wr_data_i,
   input  wire logic [cemb_pkg::ROW_W-1:0]  rd_row_a_i,
   input  wire logic [cemb_pkg::ROW_W-1:0]  rd_row_b_i,
   output logic      [cemb_pkg::DATA_W-1:0] rd_data_a_o,
   output logic      [cemb_pkg::DATA_W-1:0] rd_data_b_o
);
   import cemb_pkg::*;

   logic [DATA_W-1:0] mem_r [ROWS];

   genvar g;
   generate
      for (g = 0; g < ROWS; g++) begin : g_row
         always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               mem_r[g] <= '0;
            end else if (wr_en_i && (wr_row_i == ROW_W'(g))) begin
               mem_r[g] <= (mem_r[g] & ~wr_mask_i) | (wr_data_i & wr_mask_i);
            end
         end
      end
   endgenerate

   // No read stage: cascaded blocks add no latency
   assign rd_data_a_o = mem_r[rd_row_a_i];
   assign rd_data_b_o = mem_r[rd_row_b_i];
endmodule

// ---- hw/cemb_top.sv ----
// Embedded memory block: 2048-bit store as RAM or configured lookup table,
// optional input and output registers, AXI4-Lite setup and content load.
// Assumes the input and output clocks arrive as one-cycle enables on sys_clk_i.
//
// How it works
// - One block stores 2048 bits, the base for RAM, ROM and larger functions.
// - RAM organisation is 256x8, 512x4, 1024x2 or 2048x1, set by control.
// - The block makes its own write strobe from the input clock edge.
// - Input side and output side each run on their own clock enable.
// - Data input, address/write and output registers are enabled independently.
// - Wider words come from parallel blocks sharing one address.
// - Cascaded blocks reach 2048 words with no added read latency.
// - Lookup use loads fixed contents at setup, then returns words per address.
// - A loaded table in the 256x8 organisation maps eight address bits to eight output bits.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module cemb_top (
   input  wire logic                        sys_clk_i,
   input  wire logic                        arst_n_i,
   input  wire logic [cemb_pkg::AXI_AW-1:0] s_axi_awaddr_i,
   input  wire logic                        s_axi_awvalid_i,
   output logic                             s_axi_awready_o,
   input  wire logic [cemb_pkg::AXI_DW-1:0] s_axi_wdata_i,
   input  wire logic [3:0]                  s_axi_wstrb_i,
   input  wire logic                        s_axi_wvalid_i,
   output logic                             s_axi_wready_o,
   output logic      [1:0]                  s_axi_bresp_o,
   output logic                             s_axi_bvalid_o,
   input  wire logic                        s_axi_bready_i,
   input  wire logic [cemb_pkg::AXI_AW-1:0] s_axi_araddr_i,
   input  wire logic                        s_axi_arvalid_i,
   output logic                             s_axi_arready_o,
   output logic      [cemb_pkg::AXI_DW-1:0] s_axi_rdata_o,
   output logic      [1:0]                  s_axi_rresp_o,
   output logic                             s_axi_rvalid_o,
   input  wire logic                        s_axi_rready_i,
   input  wire logic                        in_clk_en_i,
   input  wire logic                        out_clk_en_i,
   input  wire logic                        blk_sel_i,
   input  wire logic [cemb_pkg::ADDR_W-1:0] usr_addr_i,
   input  wire logic [cemb_pkg::DATA_W-1:0] usr_wdata_i,
   input  wire logic                        usr_we_i,
   output logic      [cemb_pkg::DATA_W-1:0] usr_rdata_o
);
   import cemb_pkg::*;

   // Row of the word within the 256x8 array
   function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] a, input logic [1:0] org);
      logic [ROW_W-1:0] r;
      r = a[ROW_W-1:0];
      unique case (org)
         ORG_256X8: r = a[7:0];
         ORG_512X4: r = a[8:1];
         ORG_1KX2:  r = a[9:2];
         ORG_2KX1:  r = a[10:3];
      endcase
      return r;
   endfunction

   // First bit of the word inside its row
   function automatic logic [LANE_W-1:0] lane_of(input logic [ADDR_W-1:0] a, input logic [1:0] org);
      logic [LANE_W-1:0] l;
      l = '0;
      unique case (org)
         ORG_256X8: l = '0;
         ORG_512X4: l = {a[0], 2'h0};
         ORG_1KX2:  l = {a[1:0], 1'h0};
         ORG_2KX1:  l = a[2:0];
      endcase
      return l;
   endfunction

   function automatic logic [DATA_W-1:0] mask_of(input logic [1:0] org);
      logic [DATA_W-1:0] m;
      m = MASK_X8;
      unique case (org)
         ORG_256X8: m = MASK_X8;
         ORG_512X4: m = MASK_X4;
         ORG_1KX2:  m = MASK_X2;
         ORG_2KX1:  m = MASK_X1;
      endcase
      return m;
   endfunction

   logic [CTRL_W-1:0]  ctrl_r;
   logic [ROW_W-1:0]   load_row_r;
   logic               aw_held_r;
   logic [AXI_AW-1:0]  awaddr_r;
   logic               w_held_r;
   logic [AXI_DW-1:0]  wdata_r;
   logic [3:0]         wstrb_r;
   logic               bvalid_r;
   logic [1:0]         bresp_r;
   logic               rvalid_r;
   logic [1:0]         rresp_r;
   logic [AXI_DW-1:0]  rdata_r;
   logic [ADDR_W-1:0]  addr_r;
   logic               we_r;
   logic [DATA_W-1:0]  din_r;
   logic [DATA_W-1:0]  dout_r;

   logic [1:0]         org;
   logic               axi_wr;
   logic               load_wr;
   logic [ADDR_W-1:0]  eff_addr;
   logic               eff_we;
   logic [DATA_W-1:0]  eff_din;
   logic               usr_wr;
   logic [ROW_W-1:0]   usr_row;
   logic [LANE_W-1:0]  usr_lane;
   logic [DATA_W-1:0]  wr_mask;
   logic [DATA_W-1:0]  wr_data;
   logic [ROW_W-1:0]   wr_row;
   logic [DATA_W-1:0]  arr_usr;
   logic [DATA_W-1:0]  arr_load;
   logic [DATA_W-1:0]  rd_word;

   assign org = ctrl_r[CTRL_ORG_MSB:CTRL_ORG_LSB];

   // AXI4-Lite write channel; address and data taken in either order
   assign s_axi_awready_o = !aw_held_r && !bvalid_r;
   assign s_axi_wready_o  = !w_held_r && !bvalid_r;
   assign s_axi_bvalid_o  = bvalid_r;
   assign s_axi_bresp_o   = bresp_r;
   assign axi_wr          = aw_held_r && w_held_r && !bvalid_r;
   assign load_wr         = axi_wr && (awaddr_r == REG_LOAD_DATA) && wstrb_r[0];

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
         w_held_r  <= 1'b0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= {s_axi_awaddr_i[AXI_AW-1:2], 2'h0};
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata_i;
            wstrb_r  <= s_axi_wstrb_i;
         end
         if (axi_wr) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= (awaddr_r == REG_CTRL || awaddr_r == REG_LOAD_ADDR ||
                          awaddr_r == REG_LOAD_DATA) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready_i) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Configuration and load pointer; pointer steps after each content word
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_r     <= CTRL_RST;
         load_row_r <= '0;
      end else if (axi_wr && wstrb_r[0]) begin
         if (awaddr_r == REG_CTRL) begin
            ctrl_r <= wdata_r[CTRL_W-1:0];
         end else if (awaddr_r == REG_LOAD_ADDR) begin
            load_row_r <= wdata_r[ROW_W-1:0];
         end else if (load_wr) begin
            load_row_r <= ROW_W'(load_row_r + 1'b1);
         end
      end
   end

   // AXI4-Lite read channel
   assign s_axi_arready_o = !rvalid_r;
   assign s_axi_rvalid_o  = rvalid_r;
   assign s_axi_rresp_o   = rresp_r;
   assign s_axi_rdata_o   = rdata_r;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rvalid_r <= 1'b0;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= '0;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_r <= 1'b1;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= '0;
         unique case ({s_axi_araddr_i[AXI_AW-1:2], 2'h0})
            REG_CTRL:      rdata_r[CTRL_W-1:0] <= ctrl_r;
            REG_LOAD_ADDR: rdata_r[ROW_W-1:0]  <= load_row_r;
            REG_LOAD_DATA: rdata_r[DATA_W-1:0] <= arr_load;
            REG_STATUS: begin
               rdata_r[DATA_W-1:0]              <= usr_rdata_o;
               rdata_r[STAT_ORG_LSB+1:STAT_ORG_LSB] <= org;
            end
            default:       rresp_r <= RESP_SLVERR;
         endcase
      end else if (rvalid_r && s_axi_rready_i) begin
         rvalid_r <= 1'b0;
      end
   end

   // Optional input registers, clocked by the input-side enable
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         din_r <= '0;
      end else if (in_clk_en_i) begin
         din_r <= usr_wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         addr_r <= '0;
         we_r   <= 1'b0;
      end else if (in_clk_en_i) begin
         addr_r <= usr_addr_i;
         we_r   <= usr_we_i;
      end
   end

   assign eff_din  = ctrl_r[CTRL_DIN_REG] ? din_r : usr_wdata_i;
   assign eff_addr = ctrl_r[CTRL_ADR_REG] ? addr_r : usr_addr_i;
   assign eff_we   = ctrl_r[CTRL_ADR_REG] ? we_r : usr_we_i;

   // Upper address bits beyond the organisation's width are ignored
   // Same mapping in every block, so parallel blocks share one address
   assign usr_row  = row_of(eff_addr, org);
   assign usr_lane = lane_of(eff_addr, org);

   // Internal strobe at the input edge; content load wins a collision
   assign usr_wr  = in_clk_en_i && eff_we && blk_sel_i && !ctrl_r[CTRL_ROM] && !load_wr;
   assign wr_row  = load_wr ? load_row_r : usr_row;
   assign wr_mask = load_wr ? MASK_X8 : DATA_W'(mask_of(org) << usr_lane);
   assign wr_data = load_wr ? wdata_r[DATA_W-1:0] : DATA_W'(eff_din << usr_lane);

   cemb_array u_array (
      .sys_clk_i   (sys_clk_i),
      .arst_n_i    (arst_n_i),
      .wr_en_i     (usr_wr || load_wr),
      .wr_row_i    (wr_row),
      .wr_mask_i   (wr_mask),
      .wr_data_i   (wr_data),
      .rd_row_a_i  (usr_row),
      .rd_row_b_i  (load_row_r),
      .rd_data_a_o (arr_usr),
      .rd_data_b_o (arr_load)
   );

   // Deselected block reads zero so cascaded outputs can be ORed
   assign rd_word = blk_sel_i ? ((arr_usr >> usr_lane) & mask_of(org)) : '0;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dout_r <= '0;
      end else if (out_clk_en_i) begin
         dout_r <= rd_word;
      end
   end

   assign usr_rdata_o = ctrl_r[CTRL_OUT_REG] ? dout_r : rd_word;
endmodule

// ---- tb/cemb_checker.sv ----
// Port checks for the embedded memory block.
// Bound to cemb_top and sees only its ports.
`timescale 1ns/1ps
module cemb_checker (
   input wire logic        sys_clk_i,
   input wire logic        arst_n_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic        blk_sel_i,
   input wire logic [7:0]  usr_rdata_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   AST_AR_ANSWER: assert property (s_axi_arvalid_i && !s_axi_rvalid_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped");
   AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");
   AST_B_STALL: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("ready during response");
   AST_AR_READY: assert property (s_axi_arready_o == !s_axi_rvalid_o)
      else $error("arready wrong");
   AST_B_TIMING: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("write response timing");
   AST_B_CAUSE: assert property ($rose(s_axi_bvalid_o) |-> !$past(s_axi_awready_o) && !$past(s_axi_wready_o))
      else $error("response without both items");
   AST_SEL_ZERO: assert property (!blk_sel_i |-> usr_rdata_o == 8'h00)
      else $error("unselected block drives data");
endmodule
bind cemb_top cemb_checker u_chk (.sys_clk_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
   .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
   .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .blk_sel_i, .usr_rdata_o);

// ---- tb/cemb_fabric.sv ----
// Fabric partner: user address, data, write, select and clock enables.
// Assumes one calling process.
`timescale 1ns/1ps
module cemb_fabric (
   input  wire logic                   sys_clk_i,
   output logic                        in_clk_en_o,
   output logic                        out_clk_en_o,
   output logic                        blk_sel_o,
   output logic [cemb_pkg::ADDR_W-1:0] addr_o,
   output logic [cemb_pkg::DATA_W-1:0] wdata_o,
   output logic                        we_o
);
   import cemb_pkg::*;
   initial begin
      {in_clk_en_o, out_clk_en_o, we_o, addr_o, wdata_o} = '0;
      blk_sel_o = 1'b1;
   end
   // Gap cycles model a slow input clock
   task automatic pulse(input logic [10:0] a, input logic [7:0] d, input logic w, s, oc, input int gap);
      repeat (gap) @(posedge sys_clk_i);
      @(posedge sys_clk_i);
      addr_o <= a;
      {wdata_o, we_o, blk_sel_o, in_clk_en_o, out_clk_en_o} <= {d, w, s, 1'b1, oc};
      @(posedge sys_clk_i);
      // Scrambled so a late sample cannot pass
      {wdata_o, we_o, in_clk_en_o, out_clk_en_o} <= {~d, 3'h0};
   endtask
endmodule

// ---- tb/testbench.sv ----
// Bench: AXI4-Lite master, reference memory, fabric partner.
// Assumes one clock.
`timescale 1ns/1ps
module testbench;
   import cemb_pkg::*;
   logic        sys_clk_i, arst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
   logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
   logic        s_axi_rready_i, in_clk_en_i, out_clk_en_i, blk_sel_i, usr_we_i;
   logic [3:0]  s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [10:0] usr_addr_i;
   logic [7:0]  usr_wdata_i, usr_rdata_o;
   int          miscompares, tests_run, seed, mem[256], ctrl, i, o, a, d;
   cemb_top dut (.sys_clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
      .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
      .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
      .s_axi_rready_i, .in_clk_en_i, .out_clk_en_i, .blk_sel_i, .usr_addr_i, .usr_wdata_i, .usr_we_i, .usr_rdata_o);
   cemb_fabric fab (.sys_clk_i, .in_clk_en_o(in_clk_en_i), .out_clk_en_o(out_clk_en_i), .blk_sel_o(blk_sel_i),
      .addr_o(usr_addr_i), .wdata_o(usr_wdata_i), .we_o(usr_we_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   function automatic int ref_rd(int ad);
      int g = ctrl & 3;
      return (mem[(ad >> g) & 255] >> ((ad & ((1 << g) - 1)) * (8 >> g))) & ((1 << (8 >> g)) - 1);
   endfunction
   task automatic ref_wr(int ad, int dv);
      int g = ctrl & 3;
      int m = ((1 << (8 >> g)) - 1) << ((ad & ((1 << g) - 1)) * (8 >> g));
      mem[(ad >> g) & 255] = (mem[(ad >> g) & 255] & ~m) | ((dv << ((ad & ((1 << g) - 1)) * (8 >> g))) & m);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic hang(int n);
      if (n == 40) begin
         miscompares++;
         summarize();
      end
   endtask
   task automatic axi_wr(input logic [3:0] ad, input logic [31:0] dv, input logic [1:0] er);
      logic pa, pw, pb, da, dw;
      logic [1:0] rs;
      int n;
      {da, dw} = 2'h0;
      @(posedge sys_clk_i);
      {s_axi_awaddr_i, s_axi_wdata_i} <= {ad, dv};
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
      for (n = 0; n < 40; n++) begin
         @(negedge sys_clk_i);
         {pa, pw, pb, rs} = {s_axi_awready_o & !da, s_axi_wready_o & !dw, s_axi_bvalid_o, s_axi_bresp_o};
         @(posedge sys_clk_i);
         if (pa) s_axi_awvalid_i <= 1'b0;
         if (pw) s_axi_wvalid_i <= 1'b0;
         {da, dw} = {da | pa, dw | pw};
         if (pb) break;
      end
      s_axi_bready_i <= 1'b0;
      hang(n);
      check({30'h0, rs}, {30'h0, er});
   endtask
   task automatic axi_rd(input logic [3:0] ad, input logic [31:0] ex, input logic [1:0] er);
      logic pa, pr;
      logic [31:0] rd;
      logic [1:0] rs;
      int n;
      @(posedge sys_clk_i);
      s_axi_araddr_i <= ad;
      {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
      for (n = 0; n < 40; n++) begin
         @(negedge sys_clk_i);
         {pa, pr, rd, rs} = {s_axi_arready_o & s_axi_arvalid_i, s_axi_rvalid_o, s_axi_rdata_o, s_axi_rresp_o};
         @(posedge sys_clk_i);
         if (pa) s_axi_arvalid_i <= 1'b0;
         if (pr) break;
      end
      s_axi_rready_i <= 1'b0;
      hang(n);
      check(rd, ex);
      check({30'h0, rs}, {30'h0, er});
   endtask
   initial begin
      seed = 10512;
      {miscompares, tests_run, ctrl} = '0;
      arst_n_i = 1'b0;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = {40'h0, 4'hf};
      repeat (12) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      axi_rd(REG_CTRL, 32'h0, RESP_OKAY);
      axi_wr(REG_STATUS, 32'h3, RESP_SLVERR);
      axi_wr(REG_LOAD_ADDR, 32'h0, RESP_OKAY);
      for (i = 0; i < 256; i++) begin
         mem[i] = $random(seed) & 255;
         axi_wr(REG_LOAD_DATA, mem[i], RESP_OKAY);
      end
      axi_rd(REG_LOAD_DATA, mem[0], RESP_OKAY);
      axi_rd(REG_LOAD_ADDR, 32'h0, RESP_OKAY);
      ctrl = 32'h20;
      axi_wr(REG_CTRL, ctrl, RESP_OKAY);
      // Byte 0 strobe low: answered but ignored
      @(posedge sys_clk_i);
      s_axi_wstrb_i <= 4'h0;
      axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
      axi_rd(REG_CTRL, ctrl, RESP_OKAY);
      @(posedge sys_clk_i);
      s_axi_wstrb_i <= 4'hf;
      // Table mode: writes refused, every address looked up
      for (i = 0; i < 256; i++) begin
         fab.pulse(11'(($random(seed) & 'h700) | i), 8'($random(seed)), 1'b1, 1'b1, 1'b0, 0);
         #1 check({24'h0, usr_rdata_o}, ref_rd(i));
      end
      for (o = 0; o < 4; o++) begin
         ctrl = o;
         axi_wr(REG_CTRL, o, RESP_OKAY);
         axi_rd(REG_STATUS, (o << 8) | ref_rd(usr_addr_i), RESP_OKAY);
         for (i = 0; i < 48; i++) begin
            {a, d} = {$random(seed) & 'h7ff, $random(seed) & 255};
            fab.pulse(11'(a), 8'(d), 1'b1, 1'b1, 1'b0, $random(seed) & 3);
            ref_wr(a, d);
            #1 check({24'h0, usr_rdata_o}, ref_rd(a));
            a = $random(seed) & 'h7ff;
            fab.pulse(11'(a), 8'(d), 1'b0, 1'b1, 1'b0, 0);
            #1 check({24'h0, usr_rdata_o}, ref_rd(a));
         end
      end
      fab.pulse(11'h5, 8'(ref_rd(5) ^ 1), 1'b1, 1'b0, 1'b0, 0);
      #1 check({24'h0, usr_rdata_o}, 0);
      fab.pulse(11'h5, 8'h0, 1'b0, 1'b1, 1'b0, 0);
      #1 check({24'h0, usr_rdata_o}, ref_rd(5));
      ctrl = 32'h10;
      axi_wr(REG_CTRL, ctrl, RESP_OKAY);
      d = 0;
      for (i = 0; i < 3; i++) begin
         a = $random(seed) & 'hff;
         fab.pulse(11'(a), 8'h0, 1'b0, 1'b1, 1'b0, 0);
         #1 check({24'h0, usr_rdata_o}, d);
         fab.pulse(11'(a), 8'h0, 1'b0, 1'b1, 1'b1, 0);
         d = ref_rd(a);
         #1 check({24'h0, usr_rdata_o}, d);
      end
      ctrl = 32'h0c;
      axi_wr(REG_CTRL, ctrl, RESP_OKAY);
      {a, d} = {32'h3c, ~ref_rd(32'h3c) & 255};
      fab.pulse(11'(a), 8'(d), 1'b1, 1'b1, 1'b0, 0);
      #1 check({24'h0, usr_rdata_o}, ref_rd(a));
      fab.pulse(11'(a), 8'(~d), 1'b0, 1'b1, 1'b0, 1);
      ref_wr(a, d);
      #1 check({24'h0, usr_rdata_o}, ref_rd(a));
      summarize();
   end
endmodule
